// ==== four_channel_pwm_core.sv ====
`timescale 1ns/1ps
// Functional notes
// - four independent channels, own parameter sets
// - each channel drives complementary output pair
// - period, duty, polarity, dead times programmable
// - channel picks divided clock from shared generator
// - external triggers restart running channel counters
// - new period, duty, dead times buffered, applied glitch free
// - synchronous channels update duty, dead time together
// - dma supplies duty of synchronous channels
// - channel zero alone has spread-spectrum period
// - eight comparators against channel zero counter
// - matches raise flags, events, dma requests
// - output override aligned or immediate
// - eight faults force outputs low, high, hi-z
// - write protection blocks protected configuration loads
// - thirteen clocks: eleven prescaler, two dividers
// - sixteen-bit counter per channel
// - twelve-bit dead-time generator per pair
// - push-pull mode per channel
// - per-channel enable and disable commands
// - configuration and status reached as plain ports
module four_channel_pwm_core
  import pwm_core_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic [NUM_CH-1:0]    chanEnCmd,
  input  wire logic [NUM_CH-1:0]    chanDisCmd,
  input  wire logic [NUM_CH-1:0]    cfgLoad,
  input  wire logic                 wpActive,
  input  wire logic [NUM_CH-1:0][CLKSEL_W-1:0] clkSelIn,
  input  wire logic [NUM_CH-1:0][CNT_W-1:0]    periodIn,
  input  wire logic [NUM_CH-1:0]    polarityIn,
  input  wire logic [NUM_CH-1:0]    pushPullIn,
  input  wire logic [NUM_CH-1:0][DT_W-1:0]     deadHighIn,
  input  wire logic [NUM_CH-1:0][DT_W-1:0]     deadLowIn,
  input  wire logic [CNT_W-1:0]     spreadLimitIn,
  input  wire logic [NUM_CH-1:0]    dutyLoad,
  input  wire logic [NUM_CH-1:0][CNT_W-1:0]    dutyIn,
  input  wire logic [NUM_CH-1:0]    syncMask,
  input  wire logic [NUM_DIV-1:0][CLKSEL_W-1:0] divSelIn,
  input  wire logic [NUM_DIV-1:0][DIV_W-1:0]    divFactorIn,
  input  wire logic [NUM_CH-1:0]    extTrig,
  input  wire logic [NUM_CH-1:0]    ovrSyncEn,
  input  wire logic [NUM_CH-1:0]    ovrAsyncEn,
  input  wire logic [NUM_CH-1:0]    ovrValH,
  input  wire logic [NUM_CH-1:0]    ovrValL,
  input  wire logic [NUM_FAULT-1:0] faultIn,
  input  wire logic [NUM_FAULT-1:0] faultClear,
  input  wire logic [NUM_CH-1:0][NUM_FAULT-1:0] faultMask,
  input  wire logic [NUM_CH-1:0][1:0]          faultMode,
  input  wire logic [NUM_CMP-1:0]   cmpEn,
  input  wire logic [NUM_CMP-1:0][CNT_W-1:0]   cmpValue,
  input  wire logic [NUM_EVT-1:0][NUM_CMP-1:0] evtMask,
  input  wire logic [NUM_CMP-1:0]   cmpDmaMask,
  input  wire logic [NUM_CMP-1:0]   cmpClear,
  input  wire logic                 dmaEnable,
  input  wire logic                 dmaDutyValid,
  input  wire logic [CNT_W-1:0]     dmaDuty,
  output logic      [NUM_CH-1:0]    pwmH,
  output logic      [NUM_CH-1:0]    pwmL,
  output logic      [NUM_CH-1:0]    pwmHOeN,
  output logic      [NUM_CH-1:0]    pwmLOeN,
  output logic      [NUM_CH-1:0]    chanActive,
  output logic      [NUM_CH-1:0][CNT_W-1:0]    chanCount,
  output logic      [NUM_CMP-1:0]   cmpFlag,
  output logic      [NUM_EVT-1:0]   evtPulse,
  output logic                      dmaReq,
  output logic      [NUM_FAULT-1:0] faultFlag
);
  // prescaler mask for tap k
  function automatic logic [PRE_W-1:0] preMask(input int k);
    preMask = PRE_W'((1 << k) - 1);
  endfunction

  // shared clock generator
  logic [PRE_W-1:0]    preCnt_reg;                 // modulo-n prescaler
  logic [PRE_TAPS-1:0] preTap;                     // prescaler tick enables
  logic [DIV_W-1:0]    divCnt_reg [NUM_DIV];       // linear divider counts
  logic [NUM_DIV-1:0]  divTick_reg;                // linear divider ticks
  logic [NUM_CLK-1:0]  clkTick;                    // all thirteen enables
  // per-channel state
  logic [CNT_W-1:0] cnt_reg [NUM_CH];              // channel counters
  logic [CNT_W-1:0] periodBuf_reg [NUM_CH];        // buffered period
  logic [CNT_W-1:0] periodAct_reg [NUM_CH];        // active period
  logic [CNT_W-1:0] dutyBuf_reg [NUM_CH];          // buffered duty
  logic [CNT_W-1:0] dutyAct_reg [NUM_CH];          // active duty
  logic [DT_W-1:0]  dtHBuf_reg [NUM_CH];           // buffered high dead time
  logic [DT_W-1:0]  dtLBuf_reg [NUM_CH];           // buffered low dead time
  logic [DT_W-1:0]  dtHAct_reg [NUM_CH];           // active high dead time
  logic [DT_W-1:0]  dtLAct_reg [NUM_CH];           // active low dead time
  logic [DT_W-1:0]  deadCnt_reg [NUM_CH];          // dead-time countdown
  deadState_t       deadState_reg [NUM_CH];        // dead-time state
  logic [CLKSEL_W-1:0] clkSel_reg [NUM_CH];        // selected clock
  logic             polarity_reg [NUM_CH];         // output polarity
  logic             pushPull_reg [NUM_CH];         // push-pull mode
  logic             ppPhase_reg [NUM_CH];          // push-pull alternation
  logic             chanEn_reg [NUM_CH];           // channel enabled
  logic             updPend_reg [NUM_CH];          // own update pending
  logic             ovrSyncAct_reg [NUM_CH];       // aligned override in force
  logic             pwmH_reg [NUM_CH];
  logic             pwmL_reg [NUM_CH];
  logic             pwmHOeN_reg [NUM_CH];
  logic             pwmLOeN_reg [NUM_CH];
  logic             syncPend_reg;                  // group update pending
  logic [CNT_W-1:0] spreadBuf_reg;                 // buffered spread limit
  logic [CNT_W-1:0] spreadAct_reg;                 // active spread limit
  logic [CNT_W-1:0] spreadOff_reg;                 // spread offset 0..2*limit
  logic             spreadUp_reg;                  // spread direction
  logic [NUM_FAULT-1:0] faultLatched_reg;          // sticky fault flags
  logic [NUM_CMP-1:0]   cmpFlag_reg;               // sticky match flags
  logic [NUM_EVT-1:0]   evtPulse_reg;              // event line pulses
  logic                 dmaReq_reg;                // dma request pulse
  // decoded wires
  logic [NUM_CH-1:0] chTick;                       // channel clock enable
  logic [NUM_CH-1:0] wrap;                         // own counter wraps
  logic [NUM_CH-1:0] inSync;                       // channel in sync group
  logic [NUM_CH-1:0] cfgOk;                        // unprotected config load
  logic [NUM_CH-1:0] updNow;                       // buffers go active
  logic [NUM_CH-1:0] rawWave;                      // pre-dead-time wave
  logic [NUM_CH-1:0] faultHit;                     // channel under fault
  logic [CNT_W-1:0]  effPeriod [NUM_CH];           // period incl. spread
  logic [CNT_W-1:0]  srcCnt [NUM_CH];              // counter the wave uses
  logic [NUM_CMP-1:0] cmpMatch;                    // comparator hits
  logic               syncSet;                     // group update request

  // eleven prescaler taps plus two dividers
  genvar k;
  for (k = 0; k < PRE_TAPS; k++) begin : g_tap
    assign preTap[k] = (preCnt_reg & preMask(k)) == preMask(k);
  end
  assign clkTick = {divTick_reg, preTap};

  // prescaler free runs
  always_ff @(posedge clk_sys) begin
    if (!nrst) preCnt_reg <= '0;
    else       preCnt_reg <= preCnt_reg + PRE_ONE;
  end

  // linear dividers on selected prescaler taps, factor zero stops them
  for (k = 0; k < NUM_DIV; k++) begin : g_div
    logic divIn;
    assign divIn = (divSelIn[k] < CLKSEL_W'(PRE_TAPS)) && preTap[divSelIn[k]];
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        divCnt_reg[k]  <= '0;
        divTick_reg[k] <= 1'b0;
      end else if (divIn && divFactorIn[k] != '0) begin
        if (divCnt_reg[k] + DIV_ONE >= divFactorIn[k]) begin
          divCnt_reg[k]  <= '0;
          divTick_reg[k] <= 1'b1;
        end else begin
          divCnt_reg[k]  <= divCnt_reg[k] + DIV_ONE;
          divTick_reg[k] <= 1'b0;
        end
      end else begin
        divTick_reg[k] <= 1'b0;
      end
    end
  end

  // sync group: channel zero leads whenever any other channel joins
  assign syncSet = dmaDutyValid || |((cfgOk | dutyLoad) & inSync);
  always_ff @(posedge clk_sys) begin
    if (!nrst)              syncPend_reg <= 1'b0;
    else if (syncSet)       syncPend_reg <= 1'b1;  // set wins over wrap
    else if (wrap[0])       syncPend_reg <= 1'b0;
  end

  // channel zero spread spectrum: triangular offset stepped each period
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      spreadBuf_reg <= '0;
      spreadAct_reg <= '0;
      spreadOff_reg <= '0;
      spreadUp_reg  <= 1'b1;
    end else begin
      if (cfgOk[0]) spreadBuf_reg <= spreadLimitIn;
      if (updNow[0]) begin
        spreadAct_reg <= spreadBuf_reg;
        spreadOff_reg <= spreadBuf_reg;  // restart at centre
      end else if (wrap[0] && spreadAct_reg != '0) begin
        if (spreadUp_reg && spreadOff_reg >= CNT_W'(spreadAct_reg << 1)) spreadUp_reg <= 1'b0;
        else if (!spreadUp_reg && spreadOff_reg == '0) spreadUp_reg <= 1'b1;
        else if (spreadUp_reg) spreadOff_reg <= spreadOff_reg + CNT_ONE;
        else spreadOff_reg <= spreadOff_reg - CNT_ONE;
      end
    end
  end

  // waveform channels
  for (k = 0; k < NUM_CH; k++) begin : g_ch
    logic [CNT_W-1:0] dutyNext;
    assign inSync[k]  = (k == 0) ? |syncMask[NUM_CH-1:1] : syncMask[k];
    assign cfgOk[k]   = cfgLoad[k] && !wpActive;
    assign chTick[k]  = chanEn_reg[k] && clkSel_reg[k] < CLKSEL_W'(NUM_CLK)
                        && clkTick[clkSel_reg[k]];
    assign effPeriod[k] = (k == 0) ? periodAct_reg[k] - spreadAct_reg + spreadOff_reg
                                   : periodAct_reg[k];
    assign wrap[k]    = chTick[k] && cnt_reg[k] >= effPeriod[k];
    assign srcCnt[k]  = inSync[k] ? cnt_reg[0] : cnt_reg[k];
    assign updNow[k]  = inSync[k] ? (wrap[0] && syncPend_reg)
                                  : (wrap[k] && updPend_reg[k]);
    assign rawWave[k] = (srcCnt[k] < dutyAct_reg[k]) ^ polarity_reg[k];
    assign faultHit[k] = |((faultIn | faultLatched_reg) & faultMask[k]);
    assign dutyNext   = (dmaDutyValid && inSync[k]) ? dmaDuty : dutyIn[k];

    // enable, counter, buffers and active set
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        chanEn_reg[k]    <= 1'b0;
        cnt_reg[k]       <= CNT_RESET;
        periodBuf_reg[k] <= PERIOD_RESET;
        periodAct_reg[k] <= PERIOD_RESET;
        dutyBuf_reg[k]   <= DUTY_RESET;
        dutyAct_reg[k]   <= DUTY_RESET;
        dtHBuf_reg[k]    <= DT_RESET;
        dtLBuf_reg[k]    <= DT_RESET;
        dtHAct_reg[k]    <= DT_RESET;
        dtLAct_reg[k]    <= DT_RESET;
        clkSel_reg[k]    <= '0;
        polarity_reg[k]  <= 1'b0;
        pushPull_reg[k]  <= 1'b0;
        ppPhase_reg[k]   <= 1'b0;
        updPend_reg[k]   <= 1'b0;
        ovrSyncAct_reg[k] <= 1'b0;
      end else begin
        if (chanEnCmd[k])       chanEn_reg[k] <= 1'b1;
        else if (chanDisCmd[k]) chanEn_reg[k] <= 1'b0;
        if (!chanEn_reg[k] || extTrig[k]) cnt_reg[k] <= CNT_RESET;
        else if (wrap[k])   cnt_reg[k] <= CNT_RESET;
        else if (chTick[k]) cnt_reg[k] <= cnt_reg[k] + CNT_ONE;
        if (cfgOk[k]) begin
          periodBuf_reg[k] <= periodIn[k];
          dtHBuf_reg[k]    <= deadHighIn[k];
          dtLBuf_reg[k]    <= deadLowIn[k];
          clkSel_reg[k]    <= clkSelIn[k];
          polarity_reg[k]  <= polarityIn[k];
          pushPull_reg[k]  <= pushPullIn[k];
        end
        if (dutyLoad[k] || (dmaDutyValid && inSync[k])) dutyBuf_reg[k] <= dutyNext;
        if (cfgOk[k] || dutyLoad[k]) updPend_reg[k] <= 1'b1;  // set wins
        else if (wrap[k])            updPend_reg[k] <= 1'b0;
        if (updNow[k]) begin
          periodAct_reg[k] <= periodBuf_reg[k];
          dutyAct_reg[k]   <= dutyBuf_reg[k];
          dtHAct_reg[k]    <= dtHBuf_reg[k];
          dtLAct_reg[k]    <= dtLBuf_reg[k];
        end
        if (wrap[k]) ppPhase_reg[k] <= !ppPhase_reg[k];
        if (wrap[k] || !chanEn_reg[k]) ovrSyncAct_reg[k] <= ovrSyncEn[k];
      end
    end

    // dead-time generator: asserting edges wait out their count
    always_ff @(posedge clk_sys) begin
      if (!nrst || !chanEn_reg[k]) begin
        deadState_reg[k] <= DT_DEAD;
        deadCnt_reg[k]   <= DT_RESET;
      end else begin
        unique case (deadState_reg[k])
          DT_DEAD: begin
            if (deadCnt_reg[k] == '0)
              deadState_reg[k] <= rawWave[k] ? DT_HIGH : DT_LOW;
            else if (chTick[k]) deadCnt_reg[k] <= deadCnt_reg[k] - DT_ONE;
          end
          DT_HIGH: begin
            if (!rawWave[k]) begin
              deadState_reg[k] <= DT_DEAD;
              deadCnt_reg[k]   <= dtLAct_reg[k];
            end
          end
          DT_LOW: begin
            if (rawWave[k]) begin
              deadState_reg[k] <= DT_DEAD;
              deadCnt_reg[k]   <= dtHAct_reg[k];
            end
          end
        endcase
      end
    end

    // output stage: fault over immediate override over aligned override
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        pwmH_reg[k]    <= 1'b0;
        pwmL_reg[k]    <= 1'b0;
        pwmHOeN_reg[k] <= 1'b0;
        pwmLOeN_reg[k] <= 1'b0;
      end else if (faultHit[k]) begin
        pwmH_reg[k]    <= faultMode[k] == FAULT_HIGH;
        pwmL_reg[k]    <= faultMode[k] == FAULT_HIGH;
        pwmHOeN_reg[k] <= faultMode[k] == FAULT_HIZ;
        pwmLOeN_reg[k] <= faultMode[k] == FAULT_HIZ;
      end else begin
        pwmHOeN_reg[k] <= 1'b0;
        pwmLOeN_reg[k] <= 1'b0;
        if (ovrAsyncEn[k] || ovrSyncAct_reg[k]) begin
          pwmH_reg[k] <= ovrValH[k];
          pwmL_reg[k] <= ovrValL[k];
        end else begin
          pwmH_reg[k] <= deadState_reg[k] == DT_HIGH && (!pushPull_reg[k] || ppPhase_reg[k]);
          pwmL_reg[k] <= deadState_reg[k] == DT_LOW && (!pushPull_reg[k] || !ppPhase_reg[k]);
        end
      end
    end
    assign pwmH[k]       = pwmH_reg[k];
    assign pwmL[k]       = pwmL_reg[k];
    assign pwmHOeN[k]    = pwmHOeN_reg[k];
    assign pwmLOeN[k]    = pwmLOeN_reg[k];
    assign chanActive[k] = chanEn_reg[k];
    assign chanCount[k]  = cnt_reg[k];
  end

  // comparison units on the channel-zero counter
  for (k = 0; k < NUM_CMP; k++) begin : g_cmp
    assign cmpMatch[k] = cmpEn[k] && chTick[0] && cnt_reg[0] == cmpValue[k];
  end

  // fault latches, match flags, event lines and dma requests
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      faultLatched_reg <= '0;
      cmpFlag_reg      <= '0;
      evtPulse_reg     <= '0;
      dmaReq_reg       <= 1'b0;
    end else begin
      faultLatched_reg <= faultIn | (faultLatched_reg & ~faultClear);
      cmpFlag_reg      <= cmpMatch | (cmpFlag_reg & ~cmpClear);
      for (int e = 0; e < NUM_EVT; e++) evtPulse_reg[e] <= |(cmpMatch & evtMask[e]);
      dmaReq_reg <= |(cmpMatch & cmpDmaMask) || (dmaEnable && wrap[0]);
    end
  end
  assign faultFlag = faultLatched_reg;
  assign cmpFlag   = cmpFlag_reg;
  assign evtPulse  = evtPulse_reg;
  assign dmaReq    = dmaReq_reg;

  // checks
  pair_exclusive_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !faultHit[0] && !ovrAsyncEn[0] && !ovrSyncAct_reg[0] |=> !(pwmH[0] && pwmL[0]))
    else $error("complementary outputs both high");
  fault_force_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    faultHit[3] && faultMode[3] == FAULT_LOW |=> !pwmH[3] && !pwmL[3] && !pwmHOeN[3])
    else $error("fault did not force outputs low");
  counter_wrap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wrap[2] && !extTrig[2] |=> cnt_reg[2] == CNT_RESET ##1 cnt_reg[2] <= CNT_ONE)
    else $error("counter did not restart at period");
  chan_disable_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    chanDisCmd[0] && !chanEnCmd[0] |=> !chanActive[0] ##1 cnt_reg[0] == CNT_RESET)
    else $error("channel did not stop on disable");
  event_pulse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cmpMatch[0] && evtMask[0][0] |=> evtPulse[0] && cmpFlag[0])
    else $error("match gave no event pulse");
  sync_update_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wrap[0] && syncPend_reg && inSync[1]
    |=> dutyAct_reg[0] == $past(dutyBuf_reg[0]) && dutyAct_reg[1] == $past(dutyBuf_reg[1]))
    else $error("sync channels did not update together");
  write_protect_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wpActive && cfgLoad[2] |=> $stable(periodBuf_reg[2]) && $stable(dtHBuf_reg[2]))
    else $error("protected load changed configuration");
  dead_edge_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    chanEn_reg[0] && deadState_reg[0] == DT_HIGH && !rawWave[0] |=> deadState_reg[0] == DT_DEAD
    && deadCnt_reg[0] == $past(dtLAct_reg[0]))
    else $error("dead time not loaded on falling edge");
  async_override_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ovrAsyncEn[3] && !faultHit[3] |=> pwmH[3] == $past(ovrValH[3]) && pwmL[3] == $past(ovrValL[3]))
    else $error("immediate override not applied");
endmodule

// ==== pwm_core_pkg.sv ====
package pwm_core_pkg;
  // structure of the core
  localparam int NUM_CH    = 4;   // waveform channels
  localparam int CNT_W     = 16;  // channel counter width
  localparam int DT_W      = 12;  // dead-time width
  localparam int NUM_CMP   = 8;   // comparison units
  localparam int NUM_FAULT = 8;   // fault inputs
  localparam int NUM_EVT   = 2;   // event lines
  localparam int NUM_DIV   = 2;   // linear dividers
  localparam int PRE_TAPS  = 11;  // prescaler outputs: clk/1 .. clk/1024
  localparam int NUM_CLK   = 13;  // prescaler taps plus two divider outputs
  localparam int CLKSEL_W  = 4;   // clock select width
  localparam int DIV_W     = 8;   // linear divider factor width
  localparam int PRE_W     = PRE_TAPS - 1;
  // fault force modes
  localparam logic [1:0] FAULT_LOW  = 2'h0;
  localparam logic [1:0] FAULT_HIGH = 2'h1;
  localparam logic [1:0] FAULT_HIZ  = 2'h2;
  // reset values and unit increments
  localparam logic [CNT_W-1:0] CNT_RESET    = 16'h0000;
  localparam logic [CNT_W-1:0] PERIOD_RESET = 16'h00ff;
  localparam logic [CNT_W-1:0] DUTY_RESET   = 16'h0000;
  localparam logic [DT_W-1:0]  DT_RESET     = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE      = 16'h0001;
  localparam logic [DT_W-1:0]  DT_ONE       = 12'h001;
  localparam logic [DIV_W-1:0] DIV_ONE      = 8'h01;
  localparam logic [PRE_W-1:0] PRE_ONE      = 10'h001;
  // dead-time generator states
  typedef enum logic [1:0] {DT_DEAD, DT_HIGH, DT_LOW} deadState_t;
endpackage

// ==== gate_driver_model.sv ====
`timescale 1ns/1ps
module gate_driver_model
  import pwm_core_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic [NUM_CH-1:0] pwmH,
  input  wire logic [NUM_CH-1:0] pwmL,
  input  wire logic [NUM_CH-1:0] pwmHOeN,
  input  wire logic [NUM_CH-1:0] pwmLOeN,
  output logic      [NUM_CH-1:0] overlapSeen,
  output logic      [NUM_CH-1:0] bothSeen
);
  logic [NUM_CH-1:0] gateH, gateL;                   // gate drive, pull-down on released pins
  logic [NUM_CH-1:0] overlap_reg, hSeen_reg, lSeen_reg;  // sticky leg records
  assign gateH = pwmH & ~pwmHOeN;
  assign gateL = pwmL & ~pwmLOeN;
  // both switches of a leg on at once would short the supply
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      overlap_reg <= '0;
      hSeen_reg   <= '0;
      lSeen_reg   <= '0;
    end else begin
      overlap_reg <= overlap_reg | (gateH & gateL);
      hSeen_reg   <= hSeen_reg | gateH;
      lSeen_reg   <= lSeen_reg | gateL;
    end
  end
  assign overlapSeen = overlap_reg;
  assign bothSeen    = hSeen_reg & lSeen_reg;
endmodule

// ==== four_channel_pwm_core_test.sv ====
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH %0t %s", $time, msg); end end
module four_channel_pwm_core_test;
  import pwm_core_pkg::*;
  // fault table row: force mode and pins high, low, released
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] expPins;
  } faultRow_t;
  logic clk_sys = 1'b0, nrst = 1'b0, wpActive = 1'b0, dmaEnable = 1'b0;
  logic dmaDutyValid = 1'b0, dmaReq;
  logic [NUM_CH-1:0] chanEnCmd = '0, chanDisCmd = '0, cfgLoad = '0, polarityIn = '0;
  logic [NUM_CH-1:0] pushPullIn = '0, dutyLoad = '0, syncMask = '0, extTrig = '0;
  logic [NUM_CH-1:0] ovrSyncEn = '0, ovrAsyncEn = '0, ovrValH = '0, ovrValL = '0;
  logic [NUM_CH-1:0] pwmH, pwmL, pwmHOeN, pwmLOeN, chanActive, overlapSeen, bothSeen;
  logic [NUM_CH-1:0][CLKSEL_W-1:0] clkSelIn = '0;
  logic [NUM_CH-1:0][CNT_W-1:0] periodIn = '0, dutyIn = '0, chanCount;
  logic [NUM_CH-1:0][DT_W-1:0] deadHighIn = '0, deadLowIn = '0;
  logic [CNT_W-1:0] spreadLimitIn = '0, dmaDuty = '0, max0, max2;
  logic [NUM_DIV-1:0][CLKSEL_W-1:0] divSelIn = '0;
  logic [NUM_DIV-1:0][DIV_W-1:0] divFactorIn = '0;
  logic [NUM_FAULT-1:0] faultIn = '0, faultClear = '0, faultFlag;
  logic [NUM_CH-1:0][NUM_FAULT-1:0] faultMask = '0;
  logic [NUM_CH-1:0][1:0] faultMode = '0;
  logic [NUM_CMP-1:0] cmpEn = '0, cmpDmaMask = '0, cmpClear = '0, cmpFlag;
  logic [NUM_CMP-1:0][CNT_W-1:0] cmpValue = '0;
  logic [NUM_EVT-1:0][NUM_CMP-1:0] evtMask = '0;
  logic [NUM_EVT-1:0] evtPulse;
  int err_count = 0, compares = 0, i;
  faultRow_t rows [4] = '{'{2'h0, 3'b000}, '{2'h1, 3'b110}, '{2'h2, 3'b001}, '{2'h3, 3'b000}};

  four_channel_pwm_core u_four_channel_pwm_core (
    .clk_sys, .nrst, .chanEnCmd, .chanDisCmd, .cfgLoad, .wpActive, .clkSelIn, .periodIn,
    .polarityIn, .pushPullIn, .deadHighIn, .deadLowIn, .spreadLimitIn, .dutyLoad, .dutyIn,
    .syncMask, .divSelIn, .divFactorIn, .extTrig, .ovrSyncEn, .ovrAsyncEn, .ovrValH,
    .ovrValL, .faultIn, .faultClear, .faultMask, .faultMode, .cmpEn, .cmpValue, .evtMask,
    .cmpDmaMask, .cmpClear, .dmaEnable, .dmaDutyValid, .dmaDuty, .pwmH, .pwmL, .pwmHOeN,
    .pwmLOeN, .chanActive, .chanCount, .cmpFlag, .evtPulse, .dmaReq, .faultFlag);
  gate_driver_model u_gate_driver_model (
    .clk_sys, .nrst, .pwmH, .pwmL, .pwmHOeN, .pwmLOeN, .overlapSeen, .bothSeen);

  // 40 MHz system clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // verdict and end of run
  task automatic give_verdict();
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, several times the expected run
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    `CHK({pwmH, pwmL, pwmHOeN, pwmLOeN, chanActive}, 20'h0, "reset outputs")
    `CHK({cmpFlag, faultFlag, chanCount}, '0, "reset state")
    // ch0 short period with dead times, ch1 defaults, ch2 load under protection
    @(posedge clk_sys);
    periodIn[0] <= 16'h0009;
    dutyIn[0] <= 16'h0004;
    deadHighIn[0] <= 12'h002;
    deadLowIn[0] <= 12'h002;
    cfgLoad <= 4'h1;
    dutyLoad <= 4'h1;
    chanEnCmd <= 4'h3;
    @(posedge clk_sys);
    periodIn[2] <= 16'h0005;
    wpActive <= 1'b1;
    cfgLoad <= 4'h4;
    dutyLoad <= 4'h0;
    chanEnCmd <= 4'h4;
    @(posedge clk_sys);
    wpActive <= 1'b0;
    cfgLoad <= 4'h0;
    chanEnCmd <= 4'h0;
    @(negedge clk_sys);
    `CHK(chanActive, 4'h7, "enable commands")
    repeat (300) @(posedge clk_sys);
    max0 = '0;
    max2 = '0;
    // highest count seen on ch0 and ch2 over a window
    repeat (300) begin
      @(negedge clk_sys);
      if (chanCount[0] > max0) max0 = chanCount[0];
      if (chanCount[2] > max2) max2 = chanCount[2];
    end
    `CHK(max0, 16'h0009, "period applied at wrap")
    `CHK(max2, PERIOD_RESET, "protected load ignored")
    `CHK({overlapSeen[0], bothSeen[0]}, 2'b01, "complementary legs")
    // comparator 0 on count 3 to event line 0 and dma
    @(posedge clk_sys);
    cmpEn <= 8'h01;
    cmpValue[0] <= 16'h0003;
    evtMask[0] <= 8'h01;
    cmpDmaMask <= 8'h01;
    repeat (12) @(negedge clk_sys);
    for (i = 0; i < 40 && chanCount[0] !== 16'h0003; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    `CHK({evtPulse, dmaReq, cmpFlag[0]}, 4'b0111, "compare match")
    @(negedge clk_sys);
    `CHK({evtPulse, dmaReq}, 3'b000, "one-cycle pulses")
    // trigger restarts counter mid-period
    for (i = 0; i < 40 && chanCount[0] !== 16'h0005; i++) @(negedge clk_sys);
    @(posedge clk_sys);
    extTrig <= 4'h1;
    @(posedge clk_sys);
    extTrig <= 4'h0;
    @(negedge clk_sys);
    `CHK(chanCount[0], 16'h0000, "trigger restart")
    @(posedge clk_sys);
    chanDisCmd <= 4'h1;
    @(posedge clk_sys);
    chanDisCmd <= 4'h0;
    @(negedge clk_sys);
    `CHK(chanActive, 4'h6, "single disable")
    // immediate override on idle ch3
    @(posedge clk_sys);
    ovrValH <= 4'h8;
    ovrAsyncEn <= 4'h8;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK({pwmH[3], pwmL[3]}, 2'b10, "immediate override")
    // every fault mode beats the override, then releases
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      faultMode[3] <= rows[i].mode;
      faultMask[3] <= 8'h08;
      faultIn <= 8'h08;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK({pwmH[3], pwmL[3], pwmHOeN[3] & pwmLOeN[3]}, rows[i].expPins, "forced pins")
      `CHK({faultFlag, pwmHOeN[2]}, 9'h010, "fault latch")
      @(posedge clk_sys);
      faultIn <= 8'h00;
      faultClear <= 8'h08;
      @(posedge clk_sys);
      faultClear <= 8'h00;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK({faultFlag, pwmH[3]}, 9'h001, "fault released")
    end
    // aligned override taken at once on idle ch3
    @(posedge clk_sys);
    ovrAsyncEn <= 4'h0;
    ovrSyncEn <= 4'h8;
    ovrValH <= 4'h0;
    ovrValL <= 4'h8;
    repeat (3) @(negedge clk_sys);
    `CHK({pwmH[3], pwmL[3]}, 2'b01, "aligned override while idle")
    // ch1 linked to ch0, duty from dma, dma request at ch0 wrap
    @(posedge clk_sys);
    syncMask <= 4'h2;
    dmaEnable <= 1'b1;
    dmaDutyValid <= 1'b1;
    dmaDuty <= 16'h0004;
    chanEnCmd <= 4'h1;
    @(posedge clk_sys);
    dmaDutyValid <= 1'b0;
    chanEnCmd <= 4'h0;
    repeat (30) @(negedge clk_sys);
    `CHK(bothSeen[1:0], 2'b11, "dma duty on linked pair")
    `CHK(overlapSeen[1:0], 2'b00, "no leg overlap")
    for (i = 0; i < 40 && chanCount[0] !== 16'h0009; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    `CHK(dmaReq, 1'b1, "dma request at wrap")
    give_verdict();
  end
endmodule
